// *** verilog/adcsp_pkg.sv ***
// Package: register offsets, field layout and reset values of the polled converter block
package adcsp_pkg;
  // ---------------------------------------------------------------
  // Register offsets on the byte-wide port
  // ---------------------------------------------------------------
  localparam logic [3:0] ADCSP_OFS_LOW_TRIG = 4'h0;
  localparam logic [3:0] ADCSP_OFS_HIGH_RANGE = 4'h1;
  localparam logic [3:0] ADCSP_OFS_SCAN = 4'h2;
  localparam logic [3:0] ADCSP_OFS_DIG_LOW = 4'h3;
  localparam logic [3:0] ADCSP_OFS_STATUS = 4'h8;
  localparam logic [3:0] ADCSP_OFS_DIG_HIGH = 4'hB;
  // ---------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------
  localparam int ADCSP_EOC_BIT = 0;
  localparam int ADCSP_ARR_BIT = 1;
  localparam int ADCSP_CHAN_W = 4;
  localparam int ADCSP_RANGE_W = 4;
  localparam int ADCSP_RES_W = 12;
  localparam int ADCSP_DIG_W = 16;
  localparam int ADCSP_SCAN_START_LSB = 0;
  localparam int ADCSP_SCAN_STOP_LSB = 4;
  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [3:0] ADCSP_CHAN_RST = 4'h0;
  localparam logic [3:0] ADCSP_RANGE_RST = 4'h0;
  localparam logic [11:0] ADCSP_RES_RST = 12'h000;
  localparam logic [15:0] ADCSP_DIG_RST = 16'h0000;
  localparam logic [7:0] ADCSP_BYTE_RST = 8'h00;
  // Channel mask for the eight-pair differential arrangement
  localparam logic [3:0] ADCSP_DIFF_MASK = 4'h7;
  localparam logic [3:0] ADCSP_SE_MASK = 4'hF;
endpackage : adcsp_pkg

// *** verilog/adcsp_range_if.sv ***
// Interface: write and read path between the control logic and the range code memory
`timescale 1ns/10ps
`default_nettype none
interface adcsp_range_if #(
  parameter int AW = 4,
  parameter int DW = 4
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : adcsp_range_if
`default_nettype wire

// *** verilog/adcsp_range_mem.sv ***
// Range code memory: one code per analog channel, registered read
`timescale 1ns/10ps
`default_nettype none
module adcsp_range_mem #(
  parameter int DEPTH = 16
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  adcsp_range_if.mem port
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [adcsp_pkg::ADCSP_RANGE_W-1:0] mem_q [DEPTH];
  logic [adcsp_pkg::ADCSP_RANGE_W-1:0] rd_q;

  // Per-entry code; reset so a first conversion sees a known range
  for (genvar g = 0; g < DEPTH; g++) begin : g_entry
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        mem_q[g] <= adcsp_pkg::ADCSP_RANGE_RST;
      end else if (port.wr_en && (port.wr_addr == adcsp_pkg::ADCSP_CHAN_W'(g))) begin
        mem_q[g] <= port.wr_data;
      end
    end
  end

  // Read data from a flop, one cycle behind the address
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_q <= adcsp_pkg::ADCSP_RANGE_RST;
    end else begin
      rd_q <= mem_q[port.rd_addr];
    end
  end
  assign port.rd_data = rd_q;
endmodule : adcsp_range_mem
`default_nettype wire

// *** verilog/adcsp_top.sv ***
// Top: software-triggered, polled analog acquisition control on a byte-wide port
// Operation
// R1 - Sixteen single-ended or eight differential channels, chosen by a static switch.
// R2 - Any write to offset zero starts one conversion; data ignored.
// R3 - Status bit 0 is high while converting, zero once result is ready.
// R4 - Result read as low byte at offset zero, high byte at offset one.
// R5 - Scan register: low nibble first channel, high nibble last channel.
// R6 - Writing offset one stores a range code for the current channel.
// R7 - Sixteen digital inputs and sixteen digital outputs for external logic.
// R8 - Each trigger converts the current channel, then advances, wrapping at range end.
`timescale 1ns/10ps
`default_nettype none
module adcsp_top #(
  parameter int CHANNELS = 16
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wr_data,
  output logic [7:0] o_rd_data,
  input wire logic i_input_arrangement_switch,
  output logic o_adc_start,
  output logic [3:0] o_adc_channel,
  output logic [3:0] o_adc_range,
  input wire logic i_adc_done,
  input wire logic [11:0] i_adc_data,
  input wire logic [15:0] i_dig_in,
  output logic [15:0] o_dig_out
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic arr_s1_q;
  logic arr_s2_q;
  logic done_s1_q;
  logic done_s2_q;
  logic done_s3_q;
  logic [11:0] data_s1_q;
  logic [11:0] data_s2_q;
  logic [15:0] din_s1_q;
  logic [15:0] din_s2_q;
  logic [3:0] start_q;
  logic [3:0] stop_q;
  logic [3:0] cur_q;
  logic [3:0] cur_d;
  logic [3:0] chan_mask;
  logic busy_q;
  logic [11:0] result_q;
  logic [7:0] rd_q;
  logic [7:0] rd_d;
  logic [15:0] dout_q;
  logic start_pulse_q;
  logic [3:0] adc_chan_q;
  logic [3:0] adc_range_q;
  logic trig;
  logic done_rise;

  adcsp_range_if #(.AW(adcsp_pkg::ADCSP_CHAN_W), .DW(adcsp_pkg::ADCSP_RANGE_W)) range_bus ();

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Two flops on the switch, converter data and digital inputs, three on done; converter data is stable long before done arrives
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arr_s1_q <= 1'b0;
      arr_s2_q <= 1'b0;
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
      data_s1_q <= adcsp_pkg::ADCSP_RES_RST;
      data_s2_q <= adcsp_pkg::ADCSP_RES_RST;
      din_s1_q <= adcsp_pkg::ADCSP_DIG_RST;
      din_s2_q <= adcsp_pkg::ADCSP_DIG_RST;
    end else begin
      arr_s1_q <= i_input_arrangement_switch;
      arr_s2_q <= arr_s1_q;
      done_s1_q <= i_adc_done;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
      data_s1_q <= i_adc_data;
      data_s2_q <= data_s1_q;
      din_s1_q <= i_dig_in; // R7
      din_s2_q <= din_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Switch high means differential: only channels 0..7 exist
  assign chan_mask = arr_s2_q ? adcsp_pkg::ADCSP_DIFF_MASK : adcsp_pkg::ADCSP_SE_MASK; // R1
  assign trig = i_wr && (i_addr == adcsp_pkg::ADCSP_OFS_LOW_TRIG); // R2
  assign done_rise = done_s2_q && !done_s3_q;

  // ---------------------------------------------------------------
  // Scan range and current channel
  // ---------------------------------------------------------------
  // Next channel: wrap to first after the last one
  always_comb begin
    cur_d = cur_q;
    if (trig) begin
      if (cur_q == stop_q) begin
        cur_d = start_q; // R8
      end else begin
        cur_d = (cur_q + 4'h1) & chan_mask; // R8
      end
    end
  end

  // A scan write also restarts the walk at the first channel
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      start_q <= adcsp_pkg::ADCSP_CHAN_RST;
      stop_q <= adcsp_pkg::ADCSP_CHAN_RST;
      cur_q <= adcsp_pkg::ADCSP_CHAN_RST;
    end else if (i_wr && (i_addr == adcsp_pkg::ADCSP_OFS_SCAN)) begin
      start_q <= i_wr_data[adcsp_pkg::ADCSP_SCAN_START_LSB +: 4] & chan_mask; // R5
      stop_q <= i_wr_data[adcsp_pkg::ADCSP_SCAN_STOP_LSB +: 4] & chan_mask; // R5
      cur_q <= i_wr_data[adcsp_pkg::ADCSP_SCAN_START_LSB +: 4] & chan_mask; // R5
    end else begin
      cur_q <= cur_d;
    end
  end

  // ---------------------------------------------------------------
  // Range code memory
  // ---------------------------------------------------------------
  // Code lands at the current channel of the walk (cur_q) now
  assign range_bus.wr_en = i_wr && (i_addr == adcsp_pkg::ADCSP_OFS_HIGH_RANGE); // R6
  assign range_bus.wr_addr = cur_q; // R6
  assign range_bus.wr_data = i_wr_data[adcsp_pkg::ADCSP_RANGE_W-1:0];
  assign range_bus.rd_addr = cur_q;

  adcsp_range_mem #(.DEPTH(CHANNELS)) u_range_mem (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .port(range_bus.mem)
  );

  // ---------------------------------------------------------------
  // Conversion start and completion
  // ---------------------------------------------------------------
  // Range read lags one cycle; a code written in the cycle before the trigger is used next time
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      start_pulse_q <= 1'b0;
      adc_chan_q <= adcsp_pkg::ADCSP_CHAN_RST;
      adc_range_q <= adcsp_pkg::ADCSP_RANGE_RST;
    end else begin
      start_pulse_q <= trig; // R2
      if (trig) begin
        adc_chan_q <= cur_q; // R8
        adc_range_q <= range_bus.rd_data; // R6
      end
    end
  end

  // Busy flag; a new trigger wins over a completion in the same cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_q <= 1'b0;
      result_q <= adcsp_pkg::ADCSP_RES_RST;
    end else begin
      if (trig) begin
        busy_q <= 1'b1; // R3
      end else if (done_rise) begin
        busy_q <= 1'b0; // R3
      end
      if (done_rise) begin
        result_q <= data_s2_q; // R4
      end
    end
  end

  // ---------------------------------------------------------------
  // Digital outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dout_q <= adcsp_pkg::ADCSP_DIG_RST;
    end else if (i_wr && (i_addr == adcsp_pkg::ADCSP_OFS_DIG_LOW)) begin
      dout_q[7:0] <= i_wr_data; // R7
    end else if (i_wr && (i_addr == adcsp_pkg::ADCSP_OFS_DIG_HIGH)) begin
      dout_q[15:8] <= i_wr_data; // R7
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Unmapped offsets read zero
  always_comb begin
    rd_d = adcsp_pkg::ADCSP_BYTE_RST;
    unique case (i_addr)
      adcsp_pkg::ADCSP_OFS_LOW_TRIG: rd_d = result_q[7:0]; // R4
      adcsp_pkg::ADCSP_OFS_HIGH_RANGE: rd_d = {4'h0, result_q[11:8]}; // R4
      adcsp_pkg::ADCSP_OFS_DIG_LOW: rd_d = din_s2_q[7:0]; // R7
      adcsp_pkg::ADCSP_OFS_DIG_HIGH: rd_d = din_s2_q[15:8]; // R7
      adcsp_pkg::ADCSP_OFS_STATUS: begin
        rd_d[adcsp_pkg::ADCSP_EOC_BIT] = busy_q; // R3
        rd_d[adcsp_pkg::ADCSP_ARR_BIT] = arr_s2_q; // R1
      end
      default: rd_d = adcsp_pkg::ADCSP_BYTE_RST;
    endcase
  end

  // Read byte held until the next read strobe
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_q <= adcsp_pkg::ADCSP_BYTE_RST;
    end else if (i_rd) begin
      rd_q <= rd_d;
    end
  end

  assign o_rd_data = rd_q;
  assign o_adc_start = start_pulse_q;
  assign o_adc_channel = adc_chan_q;
  assign o_adc_range = adc_range_q;
  assign o_dig_out = dout_q;
endmodule : adcsp_top
`default_nettype wire

// *** verification/adcsp_props.sv ***
// Checker: port-level properties of the polled converter block
`timescale 1ns/10ps
`default_nettype none
module adcsp_props (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wr_data,
  input wire logic [7:0] o_rd_data,
  input wire logic o_adc_start,
  input wire logic [3:0] o_adc_channel,
  input wire logic [15:0] o_dig_out
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------
  // Trigger and scan steps
  // ----------------------------------------
  sequence trig_s;
    i_wr && i_addr == 4'h0;
  endsequence
  sequence scan_one_s;
    i_wr && i_addr == 4'h2 && i_wr_data == 8'h11;
  endsequence
  sequence dig_hi_s;
    i_wr && i_addr == 4'hB;
  endsequence
  // Any write that may move the digital outputs
  wire logic dig_wr = i_wr && (i_addr == 4'h3 || i_addr == 4'hB);
  trig_start_a: assert property (trig_s |=> o_adc_start)
    else $error("start pulse missing");
  no_trig_a: assert property (!(i_wr && i_addr == 4'h0) |=> !o_adc_start)
    else $error("start pulse without trigger");
  scan_one_a: assert property (scan_one_s ##2 trig_s |=> o_adc_channel == 4'h1)
    else $error("single channel scan wrong");
  // ----------------------------------------
  // Read port
  // ----------------------------------------
  status_pad_a: assert property (i_rd && i_addr == 4'h8 |=> o_rd_data[7:2] == 6'h00)
    else $error("status spare bits set");
  high_pad_a: assert property (i_rd && i_addr == 4'h1 |=> o_rd_data[7:4] == 4'h0)
    else $error("high byte spare bits set");
  rd_hold_a: assert property (!i_rd |=> $stable(o_rd_data))
    else $error("read data moved without read");
  unmapped_rd_a: assert property (i_rd && i_addr == 4'h4 |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
  // ----------------------------------------
  // Digital outputs
  // ----------------------------------------
  dig_low_a: assert property (i_wr && i_addr == 4'h3 |=> o_dig_out[7:0] == $past(i_wr_data))
    else $error("digital low byte wrong");
  dig_high_a: assert property (dig_hi_s |=> o_dig_out[15:8] == $past(i_wr_data))
    else $error("digital high byte wrong");
  dig_hold_a: assert property (!dig_wr |=> $stable(o_dig_out))
    else $error("digital outputs moved");
endmodule : adcsp_props
`default_nettype wire

// *** verification/adcsp_tb_top.sv ***
// Testbench: polled conversions, scan, range codes, status and digital lines
`timescale 1ns/10ps
`default_nettype none
module adc_software_trigger_poll_tb_top;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_wr_data = 8'h00;
  logic i_sw = 1'b0;
  logic i_adc_done = 1'b0;
  logic [11:0] i_adc_data = 12'h000;
  logic [15:0] i_dig_in = 16'h0000;
  logic [7:0] o_rd_data;
  logic o_adc_start;
  logic [3:0] o_adc_channel;
  logic [3:0] o_adc_range;
  logic [15:0] o_dig_out;
  logic [7:0] b;
  int miscompares = 0;
  int tests_run = 0;
  // Free-running core clock
  always #25 i_core_clk = ~i_core_clk;
  adcsp_top i_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr),
    .i_rd(i_rd), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data),
    .i_input_arrangement_switch(i_sw), .o_adc_start(o_adc_start),
    .o_adc_channel(o_adc_channel), .o_adc_range(o_adc_range), .i_adc_done(i_adc_done),
    .i_adc_data(i_adc_data), .i_dig_in(i_dig_in), .o_dig_out(o_dig_out));
  // ----------------------------------------
  // Port access and checking tasks
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk) #1;
    i_addr = a;
    i_wr_data = d;
    i_wr = 1'b1;
    @(posedge i_core_clk) #1;
    i_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_core_clk) #1;
    i_addr = a;
    i_rd = 1'b1;
    @(posedge i_core_clk) #1;
    i_rd = 1'b0;
    d = o_rd_data;
  endtask : rd
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic summarize;
    $display("Counts: %0d checks, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  // Trigger, poll until ready, then fetch both bytes; poll is bounded
  task automatic conv(input logic [3:0] ch, input logic [3:0] rg, input logic [11:0] v);
    logic [7:0] s;
    int n;
    wr(4'h0, 8'hFF);
    cmp("start", 16'h1, {15'h0, o_adc_start});
    cmp("channel", {12'h0, ch}, {12'h0, o_adc_channel});
    cmp("range", {12'h0, rg}, {12'h0, o_adc_range});
    rd(4'h8, s);
    cmp("busy", 16'h1, {15'h0, s[0]});
    i_adc_data = v;
    i_adc_done = 1'b1;
    n = 0;
    do begin
      rd(4'h8, s);
      n++;
    end while (s[0] !== 1'b0 && n < 10);
    cmp("ready", 16'h0, {15'h0, s[0]});
    // A poll that never saw ready already counted its mismatch
    if (s[0] !== 1'b0) summarize();
    i_adc_done = 1'b0;
    rd(4'h0, s);
    cmp("low", {8'h0, v[7:0]}, {8'h0, s});
    rd(4'h1, s);
    cmp("high", {12'h0, v[11:8]}, {8'h0, s});
  endtask : conv
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge i_core_clk);
    #1 i_rst_n = 1'b1;
    // Per-channel range codes, then scan 0..1 wrapping
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h05);
    wr(4'h2, 8'h11);
    wr(4'h1, 8'h09);
    wr(4'h2, 8'h10);
    conv(4'h0, 4'h5, 12'hABC);
    conv(4'h1, 4'h9, 12'h123);
    conv(4'h0, 4'h5, 12'h7E1);
    $display("test scan done");
    // Single channel stays put
    wr(4'h2, 8'h11);
    conv(4'h1, 4'h9, 12'h0F0);
    conv(4'h1, 4'h9, 12'hF0F);
    $display("test single done");
    // First above last walks through channel 15 and back to 0
    wr(4'h2, 8'h1E);
    wr(4'h1, 8'h03);
    conv(4'hE, 4'h3, 12'h8E7);
    conv(4'hF, 4'h0, 12'h001);
    conv(4'h0, 4'h5, 12'hFFE);
    conv(4'h1, 4'h9, 12'h36C);
    conv(4'hE, 4'h3, 12'hC63);
    $display("test wrap done");
    // Differential arrangement masks the channel to eight
    i_sw = 1'b1;
    repeat (3) @(posedge i_core_clk);
    rd(4'h8, b);
    cmp("status", 16'h0002, {8'h0, b});
    wr(4'h2, 8'hFF);
    conv(4'h7, 4'h0, 12'h555);
    i_sw = 1'b0;
    $display("test differential done");
    // Digital lines and unmapped places
    wr(4'h3, 8'h5A);
    wr(4'hB, 8'hC3);
    wr(4'h5, 8'hFF);
    cmp("dig_out", 16'hC35A, o_dig_out);
    i_dig_in = 16'h1234;
    repeat (3) @(posedge i_core_clk);
    rd(4'h3, b);
    cmp("dig_lo", 16'h0034, {8'h0, b});
    rd(4'hB, b);
    cmp("dig_hi", 16'h0012, {8'h0, b});
    rd(4'h4, b);
    cmp("unmapped", 16'h0000, {8'h0, b});
    $display("test digital done");
    summarize();
  end
endmodule : adc_software_trigger_poll_tb_top
bind adcsp_top adcsp_props i_props (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data),
  .o_adc_start(o_adc_start), .o_adc_channel(o_adc_channel), .o_dig_out(o_dig_out));
`default_nettype wire
